/* File: include/ulpic_consts.svh */
// Constants for the ULPI interface-control register block
// Functional notes
// [R01] Register reads at 07h-09h; write 07h, set 08h, clear 09h.
// [R02] Set-address write ORs data in; clear-address write zeroes bits marked one.
// [R03] Accesses use immediate set: 6-bit address inside transmit command byte.
// [R04] Bit 0 high carries FS/LS packets on 6-pin serial assignment.
// [R05] Variant with only four data lines never offers 6-pin serial.
// [R06] Bit 1 high carries FS/LS packets on 3-pin serial assignment.
// [R07] Leaving serial mode clears the active serial select bit automatically.
// [R08] Reference clock must keep running while a serial mode is active.
// [R09] Bit 3 gates clock output in serial modes; clock circuitry stays powered.
// [R10] Bit 4 high makes the device send resume signalling itself.
// [R11] Bit 5 high inverts the external VBUS indicator input.
// [R12] Bit 7 low enables protection with weak pull-up on STP.
// [R13] Protection on and STP unexpectedly high: weak pull-downs on data lines.
// [R14] Protection on: device detects when the link stops driving STP.
// [R15] Bit 7 high removes STP pull-up and data pull-downs.
// [R16] Protect setting leaves low-power holding behaviour unchanged.
// [R17] Bits 2 and 6 are stored and read back; bit 2 has no effect.
// [R18] All interface-control bits reset to zero.
`ifndef ULPIC_CONSTS_SVH
`define ULPIC_CONSTS_SVH
`define ULPIC_ADDR_WRITE 6'h07
`define ULPIC_ADDR_SET 6'h08
`define ULPIC_ADDR_CLEAR 6'h09
`define ULPIC_CMD_REGWR 2'h2
`define ULPIC_CMD_REGRD 2'h3
`define ULPIC_BIT_SIX_PIN 0
`define ULPIC_BIT_THREE_PIN 1
`define ULPIC_BIT_ACCESSORY 2
`define ULPIC_BIT_CLK_OUT 3
`define ULPIC_BIT_AUTORESUME 4
`define ULPIC_BIT_IND_INVERT 5
`define ULPIC_BIT_IND_PASS 6
`define ULPIC_BIT_PROTECT_DIS 7
`define ULPIC_RESET_VALUE 8'h00
`define ULPIC_STP_FLOAT_CYCLES 4'h3
`endif

/* File: include/ulpic_pkg.sv */
// Types for the ULPI interface-control register block
package ulpic_pkg;
  typedef enum logic [3:0] {
    ULPIC_IDLE = 4'b0001,
    ULPIC_WDATA = 4'b0010,
    ULPIC_TURN = 4'b0100,
    ULPIC_RDATA = 4'b1000
  } ulpic_state_e;
  typedef struct packed {
    logic [7:0] data;
    logic [5:0] addr;
    logic [1:0] kind;
  } ulpic_access_s;
endpackage : ulpic_pkg

/* File: logic/ulpic_interface_control.sv */
// ULPI link-side register port and interface-control register
`timescale 1ns/1ps
`default_nettype none
`include "ulpic_consts.svh"

// Two flops in series; the first is read by nothing but the second
module ulpic_two_stage #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] stage1;

  // A metastable first stage gets a whole cycle to settle before use
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1 <= '0;
      q_out <= '0;
    end else begin
      stage1 <= d_in;
      q_out <= stage1;
    end
  end
endmodule : ulpic_two_stage

module ulpic_interface_control #(
  parameter bit SIX_PIN_SUPPORTED = 1'b1
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ulpi_clk_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  input wire logic stp_in,
  output logic dir_out,
  output logic nxt_out,
  input wire logic serial_exit_in,
  input wire logic vbus_indicator_in,
  output logic vbus_indicator_out,
  output logic six_pin_serial_out,
  output logic three_pin_serial_out,
  output logic serial_clock_output_enable_out,
  output logic auto_resume_out,
  output logic indicator_pass_through_out,
  output logic stp_pullup_out,
  output logic data_pulldown_out,
  output logic link_floating_out,
  output logic [7:0] interface_control_out
);
  ulpic_pkg::ulpic_state_e state;
  ulpic_pkg::ulpic_access_s acc;
  logic [7:0] interface_control;
  logic [7:0] next_interface_control;
  logic [7:0] data_sync2;
  logic stp_sync2;
  logic bus_own_d2;
  logic exit_u2;
  logic exit_u3;
  logic exit_edge;
  logic ind_s2;
  logic inv_c2;
  logic [3:0] stp_high_count;
  logic protect_on;
  logic write_fire;
  logic write_commit;
  logic cmd_ok;
  logic [5:0] cmd_addr;

  // Link data bus passes two link-clock flops before any decode
  ulpic_two_stage #(
    .WIDTH(8)
  ) u_data_sync (
    .clk_in(ulpi_clk_in),
    .reset_n_in(reset_n_in),
    .d_in(data_in),
    .q_out(data_sync2)
  );

  // STP level, same two stages so it lines up with the data byte
  ulpic_two_stage #(
    .WIDTH(1)
  ) u_stp_sync (
    .clk_in(ulpi_clk_in),
    .reset_n_in(reset_n_in),
    .d_in(stp_in),
    .q_out(stp_sync2)
  );

  // Own drive enable delayed like the data: while set, the byte seen is
  // our read answer coming back off the bus, never a link command
  ulpic_two_stage #(
    .WIDTH(1)
  ) u_own_delay (
    .clk_in(ulpi_clk_in),
    .reset_n_in(reset_n_in),
    .d_in(data_oe_out),
    .q_out(bus_own_d2)
  );

  // Serial-exit level from the core clock domain
  ulpic_two_stage #(
    .WIDTH(1)
  ) u_exit_sync (
    .clk_in(ulpi_clk_in),
    .reset_n_in(reset_n_in),
    .d_in(serial_exit_in),
    .q_out(exit_u2)
  );

  // One more flop turns the synchronised level into a one-cycle edge
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      exit_u3 <= 1'b0;
    end else begin
      exit_u3 <= exit_u2;
    end
  end

  assign exit_edge = exit_u2 && !exit_u3;

  // Immediate address sits in the low six bits of the command byte
  assign cmd_addr = data_sync2[5:0]; // [R03]
  // A read answer echoed back must not decode as a spurious command
  assign cmd_ok = !bus_own_d2;

  // Command byte, then data byte for writes or turnaround and data for reads
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ulpic_pkg::ULPIC_IDLE;
      acc <= '0;
    end else begin
      unique case (state)
        ulpic_pkg::ULPIC_IDLE: begin
          if (cmd_ok && data_sync2[7:6] == `ULPIC_CMD_REGWR) begin // [R03]
            acc <= '{data: 8'h00, addr: cmd_addr, kind: `ULPIC_CMD_REGWR};
            state <= ulpic_pkg::ULPIC_WDATA;
          end else if (cmd_ok && data_sync2[7:6] == `ULPIC_CMD_REGRD) begin
            acc <= '{data: 8'h00, addr: cmd_addr, kind: `ULPIC_CMD_REGRD};
            state <= ulpic_pkg::ULPIC_TURN;
          end
        end
        ulpic_pkg::ULPIC_WDATA: begin
          acc.data <= data_sync2; // Held for the commit cycle
          state <= ulpic_pkg::ULPIC_IDLE;
        end
        ulpic_pkg::ULPIC_TURN: begin
          state <= ulpic_pkg::ULPIC_RDATA;
        end
        ulpic_pkg::ULPIC_RDATA: begin
          state <= ulpic_pkg::ULPIC_IDLE;
        end
      endcase
    end
  end

  // Commit one cycle after the data byte, from the captured copy
  assign write_fire = (state == ulpic_pkg::ULPIC_WDATA) && (acc.kind == `ULPIC_CMD_REGWR);

  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      write_commit <= 1'b0;
    end else begin
      write_commit <= write_fire;
    end
  end

  // Write, set and clear views of one register; auto clear on serial exit
  always_comb begin
    next_interface_control = interface_control;
    if (write_commit) begin
      unique case (acc.addr)
        `ULPIC_ADDR_WRITE: next_interface_control = acc.data; // [R01]
        `ULPIC_ADDR_SET: next_interface_control = interface_control | acc.data; // [R02]
        `ULPIC_ADDR_CLEAR: next_interface_control = interface_control & ~acc.data; // [R02]
        default: next_interface_control = interface_control;
      endcase
    end
    // A variant without eight data lines cannot hold the 6-pin select
    if (!SIX_PIN_SUPPORTED) begin
      next_interface_control[`ULPIC_BIT_SIX_PIN] = 1'b0; // [R05]
    end
    // Exit edge wins over a simultaneous write so the link never sees stale mode
    if (exit_edge) begin
      next_interface_control[`ULPIC_BIT_SIX_PIN] = 1'b0; // [R07]
      next_interface_control[`ULPIC_BIT_THREE_PIN] = 1'b0; // [R07]
    end
  end

  // Register state; bits 2 and 6 simply store
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      interface_control <= `ULPIC_RESET_VALUE; // [R18]
    end else begin
      interface_control <= next_interface_control; // [R17]
    end
  end

  // Read answer: direction and data turn on together after the turnaround state; dir holds one cycle more undriven
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dir_out <= 1'b0;
      nxt_out <= 1'b0;
      data_out <= 8'h00;
      data_oe_out <= 1'b0;
    end else begin
      nxt_out <= (state == ulpic_pkg::ULPIC_IDLE) && cmd_ok && data_sync2[7];
      dir_out <= (state == ulpic_pkg::ULPIC_TURN) || (state == ulpic_pkg::ULPIC_RDATA);
      data_oe_out <= (state == ulpic_pkg::ULPIC_TURN);
      if (state == ulpic_pkg::ULPIC_TURN && acc.addr >= `ULPIC_ADDR_WRITE
          && acc.addr <= `ULPIC_ADDR_CLEAR) begin
        data_out <= interface_control; // [R01]
      end else begin
        data_out <= 8'h00;
      end
    end
  end

  assign protect_on = !interface_control[`ULPIC_BIT_PROTECT_DIS]; // [R12] [R15]

  // STP held high while idle means the link has let it float onto the pull-up
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stp_high_count <= 4'h0;
    end else if (protect_on && stp_sync2 && state == ulpic_pkg::ULPIC_IDLE) begin
      if (stp_high_count != `ULPIC_STP_FLOAT_CYCLES) begin
        stp_high_count <= stp_high_count + 4'h1; // [R14]
      end
    end else begin
      stp_high_count <= 4'h0;
    end
  end

  // STP pull-up; the holding state logic elsewhere ignores it
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stp_pullup_out <= 1'b1;
    end else begin
      stp_pullup_out <= protect_on; // [R12] [R15] [R16]
    end
  end

  // Link-released flag once STP has stood high long enough
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link_floating_out <= 1'b0;
    end else begin
      link_floating_out <= protect_on && (stp_high_count == `ULPIC_STP_FLOAT_CYCLES); // [R14]
    end
  end

  // Data pull-downs act at once; waiting for the count would leave inputs floating
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_pulldown_out <= 1'b0;
    end else begin
      data_pulldown_out <= protect_on && stp_sync2; // [R13] [R15]
    end
  end

  // Six-pin select; the reference clock is trusted to run in serial modes
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      six_pin_serial_out <= 1'b0;
    end else begin
      six_pin_serial_out <= interface_control[`ULPIC_BIT_SIX_PIN]; // [R04]
    end
  end

  // Three-pin select
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      three_pin_serial_out <= 1'b0;
    end else begin
      three_pin_serial_out <= interface_control[`ULPIC_BIT_THREE_PIN]; // [R06] [R08]
    end
  end

  // Clock output gate in serial modes; clock circuitry itself stays up
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      serial_clock_output_enable_out <= 1'b0;
    end else begin
      serial_clock_output_enable_out <= interface_control[`ULPIC_BIT_CLK_OUT]; // [R09]
    end
  end

  // Automatic resume request
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      auto_resume_out <= 1'b0;
    end else begin
      auto_resume_out <= interface_control[`ULPIC_BIT_AUTORESUME]; // [R10]
    end
  end

  // Pass-through select, stored only for the indicator logic outside
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      indicator_pass_through_out <= 1'b0;
    end else begin
      indicator_pass_through_out <= interface_control[`ULPIC_BIT_IND_PASS]; // [R17]
    end
  end

  // Whole register copy for observation
  always_ff @(posedge ulpi_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      interface_control_out <= 8'h00;
    end else begin
      interface_control_out <= interface_control;
    end
  end

  // Indicator pin enters the core clock domain
  ulpic_two_stage #(
    .WIDTH(1)
  ) u_ind_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .d_in(vbus_indicator_in),
    .q_out(ind_s2)
  );

  // Invert bit crosses as a slow level; a glitch lasts at most three core
  // cycles after a register write, which the indicator tolerates
  ulpic_two_stage #(
    .WIDTH(1)
  ) u_inv_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .d_in(interface_control[`ULPIC_BIT_IND_INVERT]),
    .q_out(inv_c2)
  );

  // Indicator with optional inversion, launched from a core-domain flop
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      vbus_indicator_out <= 1'b0;
    end else begin
      vbus_indicator_out <= ind_s2 ^ inv_c2; // [R11]
    end
  end
endmodule : ulpic_interface_control
`default_nettype wire

/* File: verification/ulpic_interface_control_checker.sv */
// Checker on the ULPI register port and interface-control outputs
`timescale 1ns/1ps
`default_nettype none
module ulpic_interface_control_checker (
  input wire logic ulpi_clk_in,
  input wire logic reset_n_in,
  input wire logic serial_exit_in,
  input wire logic dir_out,
  input wire logic data_oe_out,
  input wire logic nxt_out,
  input wire logic six_pin_serial_out,
  input wire logic three_pin_serial_out,
  input wire logic auto_resume_out,
  input wire logic stp_pullup_out,
  input wire logic data_pulldown_out,
  input wire logic link_floating_out,
  input wire logic [7:0] interface_control_out
);
  default clocking cb @(posedge ulpi_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Read answer is one data cycle then one undriven cycle, dir high for both
  sequence s_dir_pair;
    dir_out ##1 dir_out ##1 !dir_out;
  endsequence
  a_dir_two_cycles: assert property ($rose(dir_out) |-> s_dir_pair)
    else $error("dir not held two cycles");
  a_oe_inside_dir: assert property (data_oe_out |-> dir_out)
    else $error("data driven outside dir");
  a_nxt_one_cycle: assert property (nxt_out |=> !nxt_out)
    else $error("nxt held too long");
  a_exit_clears: assert property (
    $rose(serial_exit_in) |-> ##[1:6] interface_control_out[1:0] == 2'h0)
    else $error("serial select not cleared");
  a_copies_follow: assert property ($stable(interface_control_out) [*3] |->
    {auto_resume_out, three_pin_serial_out, six_pin_serial_out} ==
    {interface_control_out[4], interface_control_out[1:0]})
    else $error("mode outputs disagree with register");
  a_protect_off: assert property (interface_control_out[7] [*3] |->
    !(stp_pullup_out | data_pulldown_out | link_floating_out))
    else $error("protection active while disabled");
  a_pullup_on: assert property ((!interface_control_out[7]) [*3] |-> stp_pullup_out)
    else $error("stp pull-up missing");
  a_pulldown_cause: assert property (
    $rose(data_pulldown_out) || $rose(link_floating_out) |-> !interface_control_out[7])
    else $error("protection raised while disabled");
endmodule : ulpic_interface_control_checker
bind ulpic_interface_control ulpic_interface_control_checker u_checker (
  .ulpi_clk_in(ulpi_clk_in), .reset_n_in(reset_n_in), .serial_exit_in(serial_exit_in),
  .dir_out(dir_out), .data_oe_out(data_oe_out), .nxt_out(nxt_out),
  .six_pin_serial_out(six_pin_serial_out), .three_pin_serial_out(three_pin_serial_out),
  .auto_resume_out(auto_resume_out), .stp_pullup_out(stp_pullup_out),
  .data_pulldown_out(data_pulldown_out), .link_floating_out(link_floating_out),
  .interface_control_out(interface_control_out)
);
`default_nettype wire

/* File: verification/ulpic_link_model.sv */
// Link controller model issuing ULPI register commands
`timescale 1ns/1ps
`default_nettype none
module ulpic_link_model (
  input wire logic ulpi_clk_in,
  input wire logic dev_oe_in,
  input wire logic [7:0] bus_in,
  output logic [7:0] drive_out,
  output logic stp_oe_out
);
  initial begin
    drive_out = 8'h00;
    stp_oe_out = 1'b1;
  end
  // Command byte, data byte, then idle while the synchronisers catch up
  task automatic reg_write(input logic [5:0] addr, input logic [7:0] val);
    @(posedge ulpi_clk_in);
    drive_out <= {2'h2, addr};
    @(posedge ulpi_clk_in);
    drive_out <= val;
    @(posedge ulpi_clk_in);
    drive_out <= 8'h00;
    repeat (5) @(posedge ulpi_clk_in);
  endtask : reg_write
  // After the command the bus shows inverted bits, never a stale copy
  task automatic reg_read(input logic [5:0] addr, output logic [7:0] val);
    val = 8'hxx;
    @(posedge ulpi_clk_in);
    drive_out <= {2'h3, addr};
    @(posedge ulpi_clk_in);
    drive_out <= ~{2'h3, addr};
    repeat (12) begin
      @(negedge ulpi_clk_in);
      if (dev_oe_in) val = bus_in;
    end
    @(posedge ulpi_clk_in);
    drive_out <= 8'h00;
  endtask : reg_read
  task automatic float_stp(input logic f);
    @(posedge ulpi_clk_in);
    stp_oe_out <= !f;
  endtask : float_stp
endmodule : ulpic_link_model
`default_nettype wire

/* File: verification/ulpi_interface_control_test.sv */
// Self-checking bench for the ULPI interface-control register
`timescale 1ns/1ps
`default_nettype none
module ulpi_interface_control_test;
  logic clk = 1'b0;
  logic uclk = 1'b0;
  logic rst_n = 1'b0;
  logic exit_lvl = 1'b0;
  logic vbus = 1'b0;
  logic [7:0] link_d, dev_d, ctrl, rd;
  logic oe, stp_oe, pu, pd, fl, six, three, cko, res, pass, vout;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  // Link clock runs free, serial modes included
  always #3 uclk = ~uclk;
  // Released STP reads high: stp_in is the inverse of stp_oe, whether the pull-up is on or off
  ulpic_interface_control u_dut (
    .clk_in(clk), .reset_n_in(rst_n), .ulpi_clk_in(uclk),
    .data_in(oe ? dev_d : link_d), .data_out(dev_d), .data_oe_out(oe),
    .stp_in(!stp_oe), .dir_out(), .nxt_out(), .serial_exit_in(exit_lvl),
    .vbus_indicator_in(vbus), .vbus_indicator_out(vout), .six_pin_serial_out(six),
    .three_pin_serial_out(three), .serial_clock_output_enable_out(cko),
    .auto_resume_out(res), .indicator_pass_through_out(pass), .stp_pullup_out(pu),
    .data_pulldown_out(pd), .link_floating_out(fl), .interface_control_out(ctrl));
  ulpic_link_model u_link (.ulpi_clk_in(uclk), .dev_oe_in(oe), .bus_in(dev_d),
    .drive_out(link_d), .stp_oe_out(stp_oe));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rd_check(input logic [5:0] a, input logic [7:0] exp);
    u_link.reg_read(a, rd);
    check(rd, exp);
  endtask : rd_check
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // Whole run needs a few hundred link cycles
  always @(posedge uclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_check(6'h07, 8'h00);
    check({7'h00, pu}, 8'h01);
    $display("Test reset done");
    u_link.reg_write(6'h07, 8'h5c);
    for (int a = 7; a <= 9; a++) rd_check(a[5:0], 8'h5c);
    check({4'h0, cko, res, pass, six}, 8'h0e);
    check(ctrl, 8'h5c);
    u_link.reg_write(6'h08, 8'h21);
    rd_check(6'h07, 8'h7d);
    check({7'h00, six}, 8'h01);
    @(posedge clk) vbus <= 1'b1;
    repeat (5) @(posedge clk);
    check({7'h00, vout}, 8'h00);
    u_link.reg_write(6'h09, 8'h0c);
    rd_check(6'h07, 8'h71);
    $display("Test access kinds done");
    u_link.reg_write(6'h08, 8'h02);
    check({6'h00, three, six}, 8'h03);
    @(posedge uclk) exit_lvl <= 1'b1;
    repeat (6) @(posedge uclk);
    exit_lvl <= 1'b0;
    rd_check(6'h07, 8'h70);
    check(ctrl, 8'h70);
    $display("Test serial exit done");
    u_link.reg_write(6'h0a, 8'hff);
    rd_check(6'h0a, 8'h00);
    rd_check(6'h07, 8'h70);
    $display("Test unmapped done");
    u_link.float_stp(1'b1);
    repeat (8) @(posedge uclk);
    check({5'h00, fl, pd, pu}, 8'h07);
    u_link.float_stp(1'b0);
    u_link.reg_write(6'h08, 8'h80);
    u_link.float_stp(1'b1);
    repeat (8) @(posedge uclk);
    check({5'h00, fl, pd, pu}, 8'h00);
    u_link.float_stp(1'b0);
    $display("Test protection done");
    tally_and_finish();
  end
endmodule : ulpi_interface_control_test
`default_nettype wire
